// ### logic/lsp_device.sv
// device end: configuration registers, lmfc sync machine, lane crossbar and polarity
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - subclass, delays, sync, crossbar, polarity, then enable
// - 0x01 selects one-shot, machine idle
// - 0x81 enables the sync machine
// - 0xC1 arms; next sysref edge aligns
// - transmitter sends sysref edge after arming
// - lock shows at sync status bit 3
// - subclass and two delays held, delay lanes
// - delays counted in lane processing clocks
// - two-register crossbar maps physical to logical
// - polarity bit x inverts logical lane x
// - link control bit 0 enables link
// - link control bit 6 picks checksum
// - checksum fields or registers, low byte
// - software sets vco divider per clock range
// - predivider ratio is two to code; codes above 4 give 16
// - software keeps vco within 6-12 GHz
// - software keeps feedback count 6 to 127
// - zero to three doubling interpolation stages
// - upsampling codes bypass, 2x, 4x, 8x
// - software limits input rate per mode
// - filters meet ripple and rejection limits
// - optional features reset to off
module lsp_device
  import lsp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // link
  lsp_if.device link,
  // avalon-mm register slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // user side
  output logic [39:0] lane_out [4],
  output logic lane_out_valid,
  output logic link_up,
  output logic [4:0] reference_divide_ratio,
  output logic [1:0] upsampling_select,
  output logic [7:0] config_checksum
);
  typedef enum logic [1:0] {ST_IDLE, ST_ENABLED, ST_ARMED, ST_LOCKED} lsp_sync_t;

  // =====================================================================
  // registers
  logic [7:0] sync_ctrl, vco_div, ref_div, link_ctrl, subclass, mf_delay, mf_window;
  logic [7:0] xbar_lo, xbar_hi, lane_inv, interp, opt_feat, feedback;
  lsp_sync_t sync_state;
  logic [1:0] sysref_meta;
  logic sysref_q;
  logic [7:0] lmfc_cnt;
  logic [7:0] delay_cnt;
  logic [7:0] next_readdata;
  logic [7:0] next_checksum;
  logic sysref_edge;
  logic [39:0] lane_x [4];
  logic [11:0] xbar_map;

  // crossbar field decode, used per lane
  function automatic logic [1:0] xbar_src(input logic [11:0] map, input int idx);
    xbar_src = map[idx*3 +: 2];
  endfunction

  // =====================================================================
  // avalon slave: one wait cycle then answer, keeps timing simple
  // waitrequest is a flop, idle high, low only in the second cycle of a request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_ctrl <= RST_BYTE;
      vco_div <= RST_BYTE;
      ref_div <= RST_BYTE;
      link_ctrl <= RST_BYTE;
      subclass <= RST_BYTE;
      mf_delay <= RST_BYTE;
      mf_window <= RST_BYTE;
      xbar_lo <= RST_XBAR_LO;
      xbar_hi <= RST_XBAR_HI;
      lane_inv <= RST_BYTE;
      interp <= RST_BYTE;
      opt_feat <= RST_BYTE;
      feedback <= {1'b0, FB_MIN};
    end else if (clk_en && avs_write && !avs_waitrequest) begin
      case (avs_address)
        REG_SYNC_CTRL: sync_ctrl <= avs_writedata;
        REG_VCO_DIV: vco_div <= avs_writedata;
        REG_REF_DIV: ref_div <= avs_writedata;
        REG_LINK_CTRL: link_ctrl <= avs_writedata;
        REG_SUBCLASS: subclass <= avs_writedata;
        REG_MF_DELAY: mf_delay <= avs_writedata;
        REG_MF_WINDOW: mf_window <= avs_writedata;
        REG_XBAR_LO: xbar_lo <= avs_writedata;
        REG_XBAR_HI: xbar_hi <= avs_writedata;
        REG_LANE_INV: lane_inv <= avs_writedata;
        REG_INTERP: interp <= avs_writedata;
        REG_OPT_FEAT: opt_feat <= avs_writedata;
        REG_FEEDBACK: feedback <= avs_writedata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (avs_address)
      REG_SYNC_CTRL: next_readdata = sync_ctrl;
      REG_SYNC_STAT: next_readdata = {4'h0, sync_state == ST_LOCKED, 3'h0};
      REG_VCO_DIV: next_readdata = vco_div;
      REG_REF_DIV: next_readdata = ref_div;
      REG_LINK_CTRL: next_readdata = link_ctrl;
      REG_SUBCLASS: next_readdata = subclass;
      REG_MF_DELAY: next_readdata = mf_delay;
      REG_MF_WINDOW: next_readdata = mf_window;
      REG_XBAR_LO: next_readdata = xbar_lo;
      REG_XBAR_HI: next_readdata = xbar_hi;
      REG_LANE_INV: next_readdata = lane_inv;
      REG_INTERP: next_readdata = interp;
      REG_OPT_FEAT: next_readdata = opt_feat;
      REG_FEEDBACK: next_readdata = feedback;
      REG_CHECKSUM: next_readdata = config_checksum;
      default: next_readdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 8'h00;
    end else if (clk_en && avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // =====================================================================
  // sysref arrives from the pin: two flops before any use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sysref_meta <= 2'b00;
      sysref_q <= 1'b0;
    end else if (clk_en) begin
      sysref_meta <= {sysref_meta[0], link.sysref};
      sysref_q <= sysref_meta[1];
    end
  end
  assign sysref_edge = sysref_meta[1] & ~sysref_q;

  // =====================================================================
  // one-shot sync machine, follows control writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_state <= ST_IDLE;
    end else if (clk_en) begin
      case (sync_state)
        ST_IDLE: if (sync_ctrl[SYNC_EN_BIT]) sync_state <= ST_ENABLED;
        ST_ENABLED: begin
          if (!sync_ctrl[SYNC_EN_BIT]) sync_state <= ST_IDLE;
          else if (sync_ctrl[SYNC_ARM_BIT]) sync_state <= ST_ARMED;
        end
        ST_ARMED: begin
          if (!sync_ctrl[SYNC_EN_BIT]) sync_state <= ST_IDLE;
          else if (sysref_edge) sync_state <= ST_LOCKED;
        end
        ST_LOCKED: if (!sync_ctrl[SYNC_EN_BIT]) sync_state <= ST_IDLE;
        default: sync_state <= ST_IDLE;
      endcase
    end
  end

  // lmfc phase counter; only an armed edge realigns it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_cnt <= 8'h00;
    end else if (clk_en) begin
      if (sync_state == ST_ARMED && sysref_edge) lmfc_cnt <= 8'h00;
      else if (lmfc_cnt == MF_PERIOD - 8'h01) lmfc_cnt <= 8'h00;
      else lmfc_cnt <= lmfc_cnt + 8'h01;
    end
  end

  // =====================================================================
  // link bring-up: release data after delay counted in processing clocks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt <= 8'h00;
      link_up <= 1'b0;
    end else if (clk_en) begin
      if (!link_ctrl[LINK_EN_BIT]) begin
        delay_cnt <= 8'h00;
        link_up <= 1'b0;
      end else if (!link_up && (subclass[0] == 1'b0 || sync_state == ST_LOCKED)) begin
        if (delay_cnt >= mf_delay + mf_window) link_up <= 1'b1;
        else delay_cnt <= delay_cnt + 8'h01;
      end
    end
  end
  assign link.sync_request_n = link_up;

  // =====================================================================
  // crossbar and polarity per logical lane
  assign xbar_map = {xbar_hi[5:0], xbar_lo[5:0]};
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane_x[g] = link.lane_data[xbar_src(xbar_map, g)] ^ {LANE_W{lane_inv[g]}};
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lane_out_valid <= 1'b0;
      for (int i = 0; i < LANES; i++) lane_out[i] <= '0;
    end else if (clk_en) begin
      lane_out_valid <= link.lane_valid & link_up;
      for (int i = 0; i < LANES; i++) lane_out[i] <= lane_x[i];
    end
  end

  // =====================================================================
  // pll divider decode, interpolation mode, checksum
  always_comb begin
    if (link_ctrl[CHK_SEL_BIT]) begin
      next_checksum = subclass + mf_delay + mf_window + xbar_lo + xbar_hi;
    end else begin
      next_checksum = {7'h00, subclass[0]} + {5'h00, interp[2:0]} + {7'h00, sync_ctrl[0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reference_divide_ratio <= 5'h01;
      upsampling_select <= 2'h0;
      config_checksum <= 8'h00;
    end else if (clk_en) begin
      reference_divide_ratio <= (ref_div[2:0] > 3'h4) ? 5'h10 : 5'(1 << ref_div[2:0]);
      upsampling_select <= interp[1:0]; // filter chain downstream keeps its own limits
      config_checksum <= next_checksum;
    end
  end
endmodule

// ### logic/lsp_host.sv
// transmitter end: drives lanes, frames and sysref edges
`timescale 1ns/100ps
module lsp_host
  import lsp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // link
  lsp_if.host link,
  // user side
  input wire logic sysref_req,
  input wire logic [39:0] user_data [4],
  input wire logic user_valid,
  output logic link_ready
);
  logic sysref_q;
  logic [1:0] sync_meta;
  logic [39:0] data_q [4];
  logic valid_q;

  // =====================================================================
  // sync request input comes from the other domain side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= 2'b00;
    end else if (clk_en) begin
      sync_meta <= {sync_meta[0], link.sync_request_n};
    end
  end

  // one sysref edge per request, sysref_req registered once with no check of arming
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sysref_q <= 1'b0;
    end else if (clk_en) begin
      sysref_q <= sysref_req;
    end
  end

  // data only flows once the device releases its request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      link_ready <= 1'b0;
      for (int i = 0; i < LANES; i++) begin
        data_q[i] <= '0;
      end
    end else if (clk_en) begin
      link_ready <= sync_meta[1];
      valid_q <= user_valid & sync_meta[1];
      for (int i = 0; i < LANES; i++) begin
        data_q[i] <= user_data[i];
      end
    end
  end

  assign link.sysref = sysref_q;
  assign link.lane_valid = valid_q;
  assign link.lane_data = data_q;
endmodule

// ### pkg/lsp_if.sv
// interface: lanes and sysref between transmitter end and device end
`timescale 1ns/100ps
interface lsp_if;
  logic [39:0] lane_data [4];
  logic lane_valid;
  logic sysref;
  logic sync_request_n;
  modport device (input lane_data, input lane_valid, input sysref, output sync_request_n);
  modport host (output lane_data, output lane_valid, output sysref, input sync_request_n);
endinterface

// ### pkg/lsp_pkg.sv
// package: register map, field layout, reset values and enums of the link/pll/interp configuration block
package lsp_pkg;
  // =====================================================================
  // register offsets (device register space)
  localparam logic [11:0] REG_SYNC_CTRL = 12'h03A;
  localparam logic [11:0] REG_SYNC_STAT = 12'h03B;
  localparam logic [11:0] REG_VCO_DIV = 12'h08B;
  localparam logic [11:0] REG_REF_DIV = 12'h08C;
  localparam logic [11:0] REG_LINK_CTRL = 12'h300;
  localparam logic [11:0] REG_SUBCLASS = 12'h301;
  localparam logic [11:0] REG_MF_DELAY = 12'h304;
  localparam logic [11:0] REG_MF_WINDOW = 12'h306;
  localparam logic [11:0] REG_XBAR_LO = 12'h308;
  localparam logic [11:0] REG_XBAR_HI = 12'h309;
  localparam logic [11:0] REG_LANE_INV = 12'h334;
  localparam logic [11:0] REG_INTERP = 12'h112;
  localparam logic [11:0] REG_OPT_FEAT = 12'h113;
  localparam logic [11:0] REG_FEEDBACK = 12'h08D;
  localparam logic [11:0] REG_CHECKSUM = 12'h45D;
  // =====================================================================
  // field positions and command values
  localparam int SYNC_EN_BIT = 7;
  localparam int SYNC_ARM_BIT = 6;
  localparam int SYNC_LOCK_BIT = 3;
  localparam int LINK_EN_BIT = 0;
  localparam int CHK_SEL_BIT = 6;
  localparam logic [7:0] SYNC_MODE_ONESHOT = 8'h01;
  localparam logic [7:0] SYNC_CMD_ENABLE = 8'h81;
  localparam logic [7:0] SYNC_CMD_ARM = 8'hC1;
  localparam int LANES = 4;
  localparam int LANE_W = 40;
  localparam int PCLK_DIV = 40;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_XBAR_LO = 8'h08;
  localparam logic [7:0] RST_XBAR_HI = 8'h1A;
  localparam logic [6:0] FB_MIN = 7'h06;
  localparam logic [6:0] FB_MAX = 7'h7F;
  localparam logic [7:0] MF_PERIOD = 8'h10;
  // =====================================================================
  // enumerations
  typedef enum logic [1:0] {LSP_BYPASS, LSP_X2, LSP_X4, LSP_X8} lsp_interp_t;
endpackage

// ### tb/lsp_asserts.sv
// checker: wire-level relations on the link between both ends
`timescale 1ns/100ps
module lsp_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link wires
  input wire logic [39:0] lane_data [4],
  input wire logic lane_valid,
  input wire logic sysref,
  input wire logic sync_request_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ======================================================================
  // link up needs a register write plus a delay count, never at once
  sequence s_release;
    $rose(rst_n);
  endsequence
  sequence s_up;
    !sync_request_n ##1 sync_request_n;
  endsequence
  property p_down_rst;
    s_release |-> !sync_request_n && !lane_valid;
  endproperty
  a_down_rst: assert property (p_down_rst) else $error("link up at reset release");
  property p_up_late;
    s_release |-> !sync_request_n [*4];
  endproperty
  a_up_late: assert property (p_up_late) else $error("link up too soon");
  // link enable is a level, so once up it stays up for at least four cycles
  property p_up_hold;
    s_up |=> sync_request_n [*4];
  endproperty
  a_up_hold: assert property (p_up_hold) else $error("link dropped");
  // data may only flow three edges after the device releases its request
  sequence s_held_down;
    !sync_request_n;
  endsequence
  property p_valid_gated;
    lane_valid |-> $past(sync_request_n, 3);
  endproperty
  a_valid_gated: assert property (p_valid_gated) else $error("lane data valid before link up");
  property p_down_blocks;
    s_held_down |-> ##3 !lane_valid;
  endproperty
  a_down_blocks: assert property (p_down_blocks) else $error("lane data valid while link down");
  property p_rst_quiet;
    s_release |-> !sysref && lane_data[0] == 40'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("link wires busy at reset release");
  c_sysref: cover property ($rose(sysref));
endmodule

// ### tb/tb_top.sv
// testbench: register bring-up, sync, pll, upsampling and lane mapping
`timescale 1ns/100ps
module tb_top;
  import lsp_pkg::*;
  // ======================================================================
  // signals
  logic clk_sys, rst_n, clk_en, sysref_req, user_valid, link_ready;
  logic [39:0] user_data [4];
  logic [11:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, lane_out_valid, link_up;
  logic [7:0] avs_writedata, avs_readdata, config_checksum, q;
  logic [39:0] lane_out [4];
  logic [4:0] reference_divide_ratio;
  logic [1:0] upsampling_select;
  logic [11:0] ra [5] = '{REG_SUBCLASS, REG_MF_DELAY, REG_MF_WINDOW, REG_VCO_DIV, REG_FEEDBACK};
  // vco code 2 for a mid clock range, feedback count at its top limit
  logic [7:0] rv [5] = '{8'h01, 8'h04, 8'h02, 8'h02, 8'h7F};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  lsp_if link();
  lsp_host lsp_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .link(link),
    .sysref_req(sysref_req), .user_data(user_data), .user_valid(user_valid), .link_ready(link_ready));
  lsp_device lsp_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lane_out(lane_out),
    .lane_out_valid(lane_out_valid), .link_up(link_up), .reference_divide_ratio(reference_divide_ratio),
    .upsampling_select(upsampling_select), .config_checksum(config_checksum));
  lsp_asserts lsp_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n), .lane_data(link.lane_data),
    .lane_valid(link.lane_valid), .sysref(link.sysref), .sync_request_n(link.sync_request_n));
  // ======================================================================
  // clock, timeout and shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low; one idle edge keeps calls apart
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic sysref_pulse();
    sysref_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sysref_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  // ======================================================================
  // main sequence
  initial begin
    int n;
    rst_n = 1'b0;
    clk_en = 1'b1;
    sysref_req = 1'b0;
    user_valid = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 8'h00;
    foreach (user_data[i]) user_data[i] = {8'h00, 32'(i) * 32'h1111_1111};
    repeat (4) @(posedge clk_sys);
    chk(reference_divide_ratio, 40'h1);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(REG_SYNC_STAT, RST_BYTE);
    rd_chk(REG_XBAR_LO, RST_XBAR_LO);
    rd_chk(REG_XBAR_HI, RST_XBAR_HI);
    rd_chk(REG_OPT_FEAT, RST_BYTE);
    bus(1'b1, 12'h7FF, 8'hA5);
    rd_chk(12'h7FF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ra[i], rv[i]);
      rd_chk(ra[i], rv[i]);
    end
    bus(1'b1, REG_SYNC_CTRL, SYNC_MODE_ONESHOT);
    rd_chk(REG_SYNC_CTRL, SYNC_MODE_ONESHOT);
    sysref_pulse();
    bus(1'b0, REG_SYNC_STAT, 8'h00);
    chk(q[SYNC_LOCK_BIT], 1'b0);
    bus(1'b1, REG_SYNC_CTRL, SYNC_CMD_ENABLE);
    rd_chk(REG_SYNC_CTRL, SYNC_CMD_ENABLE);
    sysref_pulse();
    bus(1'b0, REG_SYNC_STAT, 8'h00);
    chk(q[SYNC_LOCK_BIT], 1'b0);
    bus(1'b1, REG_SYNC_CTRL, SYNC_CMD_ARM);
    sysref_pulse();
    bus(1'b0, REG_SYNC_STAT, 8'h00);
    chk(q[SYNC_LOCK_BIT], 1'b1);
    for (int c = 1; c < 5; c++) begin
      bus(1'b1, REG_REF_DIV, 8'(c));
      @(posedge clk_sys);
      chk(reference_divide_ratio, 40'(1 << c));
    end
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, REG_INTERP, 8'(c)); // bench lanes stay far below every mode's rate limit
      @(posedge clk_sys);
      chk(upsampling_select, 40'(c));
    end
    // field sum: subclass bit, upsampling code 3, one-shot bit
    rd_chk(REG_CHECKSUM, 8'h05);
    // reversed lanes: logical g from physical 3-g, lanes 0 and 2 inverted
    bus(1'b1, REG_XBAR_LO, 8'h13);
    bus(1'b1, REG_XBAR_HI, 8'h01);
    bus(1'b1, REG_LANE_INV, 8'h05);
    user_valid <= 1'b1;
    bus(1'b1, REG_LINK_CTRL, 8'h41);
    rd_chk(REG_LINK_CTRL, 8'h41);
    n = 0;
    while ((link_up !== 1'b1 || lane_out_valid !== 1'b1) && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk(link_up, 1'b1);
    chk(lane_out_valid, 1'b1);
    repeat (4) @(posedge clk_sys);
    chk(link_ready, 1'b1);
    for (int g = 0; g < 4; g++)
      chk(lane_out[g], user_data[3 - g] ^ {40{g % 2 == 0}});
    // register sum: subclass, both delays, both crossbar bytes
    rd_chk(REG_CHECKSUM, 8'h1B);
    chk(config_checksum, 8'h1B);
    close_out();
  end
endmodule
